// [verilog/brq_observer.sv]
/*
  Bus request observer: a memory or I/O agent that watches the two request
  clocks, checks parity, drives the address error in the error phase and
  reports decoded fields over APB.
  Assumes pins arrive asynchronously and an external wire resolves ADDRESS_ERROR.
*/
// Summary of operation
// - Command bit 0 means write data and handshake; bits 1 or 2 mean memory.
// - Caching agents snoop every memory command seen on the bus.
// - Read bit: 0 code, 1 data; write bit: 0 writeback, 1 write.
// - Initiator drives data-size 00; responders ignore it.
// - Address space 00 below 4 GB, 01 up to 64 GB; others reserved.
// - 32-bit agents respond only to 00; 36-bit agents to 00 or 01.
// - Length 00 up to 8 bytes, 01 16, 10 32; 11 reserved.
// - Upper parity 35..24, lower 23..3, request parity commands plus strobe.
// - Parity uses electrical levels; even count of lows is correct.
// - Second clock attribute field carries memory type; other codes reserved.
// - Reply tag: type bit 7, agent 6..4, transaction 3..0.
// - Outstanding deferrable tags unique; freed after snoop without defer.
// - Byte enable n governs data byte n for narrow transfers.
// - Special cycles coded 01..07 on byte enables; others reserved.
// - Management RAM accesses accepted only by agents providing that RAM.
// - Postpone-allowed never set for locked, deferred-reply or writeback lines.
// - Error phase is one clock, three clocks after the strobe.
// - With driver enabled, check parity and assert address error on mismatch.
// - No upper parity error for addresses outside the agent's range.
// - Sampled error cancels request, resets arbitration; one retry then hard.
`timescale 1ns/1ps
`default_nettype none
module brq_observer
  import brq_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // APB register port
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Request pins from the bus
  input  wire brq_pins_t   BUS_IN,
  // Address error open-drain driver
  output logic             ADDRESS_ERROR_O,
  output logic             ADDRESS_ERROR_OE,
  // Responder strobes
  output logic             WRITE_DATA_READY_N,
  output logic             ARB_PRIORITY_RESET
);
  typedef enum logic [2:0] {IDLE, REQ_B, WAIT, ERR, SNOOP} brq_state_t;

  brq_state_t  state_r;
  brq_pins_t   sync1_r, sync2_r;
  brq_req_t    req_r;
  logic [3:0]  ctrl_r;
  logic [ST_BITS-1:0] sts_r, sts_set;
  logic        perr_up_r, perr_lo_r, perr_rp_r, perr_r;
  logic        address_error_r, arb_r, wdr_n_r, cancel_now;
  logic        tried_r, same_addr, hard_now;
  logic [35:3] tried_addr_r;
  logic [15:0] cancel_cnt_r, req_cnt_r;
  logic        tag_busy_r [TAGS];
  logic        apb_wr, apb_rd;

  // Two-stage synchroniser on every bus pin; only sync2_r is read.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= BUS_IN;
      sync2_r <= sync1_r;
    end
  end

  // Parity on raw levels: an odd count of low lines is an error.
  logic up_bad, lo_bad, rp_bad;
  assign up_bad = ^(~{sync2_r.addr_n[35:24], sync2_r.ap_n[1]});
  assign lo_bad = ^(~{sync2_r.addr_n[23:3], sync2_r.ap_n[0]});
  assign rp_bad = ^(~{sync2_r.cmd_n, sync2_r.strobe_n, sync2_r.rp_n});

  // Decoded fields of the current request, logical sense.
  logic [1:0] asz, len, dsz;
  logic       is_mem, is_write, in_range, accept, special, mgmt;
  assign asz      = req_r.cmd_a[4:3];
  assign len      = req_r.cmd_b[1:0];
  assign dsz      = req_r.cmd_b[4:3];
  assign is_mem   = req_r.cmd_a[1] | req_r.cmd_a[2];
  assign is_write = req_r.cmd_a[0];
  assign in_range = (asz == ASZ_4G) || (asz == ASZ_64G && ctrl_r[CTRL_WIDE]);
  assign mgmt     = req_r.exf[EXF_MGMT];
  assign accept   = (!is_mem || in_range) && (!mgmt || ctrl_r[CTRL_OWN_MEM]);
  assign special  = req_r.cmd_a == CMD_SPECIAL && req_r.cmd_b[1:0] == CMDB_SPECIAL;

  // Request tracker: strobe clock, second clock, wait, error phase, snoop.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= IDLE;
    end else begin
      unique case (state_r)
        IDLE:    if (!sync2_r.strobe_n) state_r <= REQ_B;
        REQ_B:   state_r <= WAIT;
        WAIT:    state_r <= ERR;
        ERR:     state_r <= SNOOP;
        SNOOP:   state_r <= IDLE;
      endcase
    end
  end

  // Capture both request clocks; the address drops its low three bits.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req_r <= '0;
    end else if (state_r == IDLE && !sync2_r.strobe_n) begin
      req_r.cmd_a  <= ~sync2_r.cmd_n;
      req_r.addr   <= ~sync2_r.addr_n;
      req_r.locked <= !sync2_r.lock_n;
    end else if (state_r == REQ_B) begin
      req_r.cmd_b <= ~sync2_r.cmd_n;
      req_r.attr  <= ~sync2_r.addr_n[31:24];
      req_r.tag   <= ~sync2_r.addr_n[23:16];
      req_r.be    <= ~sync2_r.addr_n[15:8];
      req_r.exf   <= ~sync2_r.addr_n[7:3];
    end
  end

  // Parity is checked in both request clocks and held until the error phase.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      perr_up_r <= 1'b0;
      perr_lo_r <= 1'b0;
      perr_rp_r <= 1'b0;
    end else if (state_r == IDLE && !sync2_r.strobe_n) begin
      perr_up_r <= up_bad;
      perr_lo_r <= lo_bad;
      perr_rp_r <= rp_bad;
    end else if (state_r == REQ_B) begin
      perr_up_r <= perr_up_r | up_bad;
      perr_lo_r <= perr_lo_r | lo_bad;
      perr_rp_r <= perr_rp_r | rp_bad;
    end
  end

  // Upper parity is not blamed when the address is beyond our reach.
  assign perr_r = (perr_up_r && in_range) || perr_lo_r || perr_rp_r;

  // Address error driven for exactly the error-phase clock.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      address_error_r <= 1'b0;
    end else begin
      address_error_r <= state_r == WAIT && ctrl_r[CTRL_DRV_EN] && perr_r;
    end
  end
  assign ADDRESS_ERROR_O  = 1'b0;
  assign ADDRESS_ERROR_OE = address_error_r;

  // The error seen on the wire is ours or another agent's.
  assign cancel_now = state_r == ERR && ctrl_r[CTRL_OBS_EN] &&
                      (address_error_r || !sync2_r.address_error_n);
  assign same_addr  = tried_r && tried_addr_r == req_r.addr;
  assign hard_now   = cancel_now && same_addr;

  // One retry per cancelled address, then a hard error.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tried_r      <= 1'b0;
      tried_addr_r <= '0;
    end else if (cancel_now) begin
      tried_r      <= !same_addr;
      tried_addr_r <= req_r.addr;
    end else if (state_r == ERR && tried_r && tried_addr_r == req_r.addr) begin
      tried_r <= 1'b0;
    end
  end

  // Arbitration priority returns to its reset order after a cancel.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      arb_r <= 1'b0;
    end else begin
      arb_r <= cancel_now;
    end
  end
  assign ARB_PRIORITY_RESET = arb_r;

  // Write handshake for accepted writes, given in the snoop clock.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wdr_n_r <= 1'b1;
    end else begin
      wdr_n_r <= !(state_r == ERR && !cancel_now && is_write && accept);
    end
  end
  assign WRITE_DATA_READY_N = wdr_n_r;

  // Outstanding deferrable tags; a tag frees when the snoop shows no defer.
  logic tag_clash;
  assign tag_clash = tag_busy_r[req_r.tag] && req_r.exf[EXF_DEN];
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < TAGS; i++) tag_busy_r[i] <= 1'b0;
    end else if (state_r == ERR && !cancel_now && req_r.exf[EXF_DEN]) begin
      tag_busy_r[req_r.tag] <= 1'b1;
    end else if (state_r == SNOOP && sync2_r.defer_n) begin
      tag_busy_r[req_r.tag] <= 1'b0;
    end
  end

  // Violations evaluated in the wait clock; cancel and hard events in the error phase.
  always_comb begin
    sts_set = '0;
    if (state_r == WAIT) begin
      sts_set[ST_PARITY] = perr_r && ctrl_r[CTRL_DRV_EN];
      sts_set[ST_DSZ]    = dsz != DSZ_OK;
      sts_set[ST_RSVD]   = (is_mem && asz[1]) || len == 2'h3 ||
                           (is_mem && req_r.attr != ATTR_UC &&
                            (req_r.attr < ATTR_WC || req_r.attr > ATTR_WB)) ||
                           (special && (req_r.be < SPC_FIRST || req_r.be > SPC_LAST));
      sts_set[ST_DEN]    = req_r.exf[EXF_DEN] &&
                           (req_r.locked || req_r.cmd_a == CMD_DEF_REPLY ||
                            req_r.cmd_a[2:0] == 3'h5)
                           || (req_r.exf[EXF_SPLIT] && !req_r.locked);
      sts_set[ST_TAG]    = tag_clash;
      sts_set[ST_LEN16]  = is_mem && len == LEN_16;
    end
    sts_set[ST_CANCEL] = cancel_now;
    sts_set[ST_HARD]   = hard_now;
  end

  // APB slave: zero wait states, error on unmapped offsets.
  assign apb_wr  = PSEL && PENABLE && PWRITE;
  assign apb_rd  = PSEL && PENABLE && !PWRITE;
  assign PREADY  = 1'b1;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_wr && PADDR == OFS_CTRL) begin
      ctrl_r <= PWDATA[3:0];
    end
  end

  // Sticky status: write one to clear, a new event wins over the clear.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sts_r <= '0;
    end else if (apb_wr && PADDR == OFS_STATUS) begin
      sts_r <= (sts_r & ~PWDATA[ST_BITS-1:0]) | sts_set;
    end else begin
      sts_r <= sts_r | sts_set;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cancel_cnt_r <= '0;
      req_cnt_r    <= '0;
    end else begin
      if (cancel_now) cancel_cnt_r <= cancel_cnt_r + 16'h0001;
      if (state_r == ERR) req_cnt_r <= req_cnt_r + 16'h0001;
    end
  end

  logic rd_hit;
  always_comb begin
    PRDATA = '0;
    rd_hit = 1'b1;
    unique case (PADDR)
      OFS_CTRL:   PRDATA = {28'h0, ctrl_r};
      OFS_STATUS: PRDATA = {24'h0, sts_r};
      OFS_FIELDA: PRDATA = {19'h0, req_r.cmd_b, 3'h0, req_r.cmd_a};
      OFS_ADDRLO: PRDATA = {req_r.addr[31:3], 3'h0};
      OFS_ADDRHI: PRDATA = {28'h0, req_r.addr[35:32]};
      OFS_FIELDB: PRDATA = {3'h0, req_r.exf, req_r.be, req_r.tag, req_r.attr};
      OFS_COUNT:  PRDATA = {req_cnt_r, cancel_cnt_r};
      OFS_DECODE: PRDATA = {20'h0, req_r.be[3:0], 3'h0, special, accept,
                            req_r.cmd_a[1], is_write, is_mem};
      default:    rd_hit = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !rd_hit;

  // Checks on the design's own behaviour.
  property p_err_one_clock;
    @(posedge MCLK) disable iff (!RST_N)
    ADDRESS_ERROR_OE |=> !ADDRESS_ERROR_OE;
  endproperty
  a_err_one_clock: assert property (p_err_one_clock) else $error("address error longer than one clock");

  property p_err_phase_place;
    @(posedge MCLK) disable iff (!RST_N)
    (state_r == IDLE && !sync2_r.strobe_n) |-> ##3 (state_r == ERR);
  endproperty
  a_err_phase_place: assert property (p_err_phase_place) else $error("error phase not three clocks on");

  property p_err_needs_cause;
    @(posedge MCLK) disable iff (!RST_N)
    ADDRESS_ERROR_OE |-> $past(perr_r) && $past(state_r == WAIT);
  endproperty
  a_err_needs_cause: assert property (p_err_needs_cause) else $error("address error without parity fault");

  property p_err_on_fault;
    @(posedge MCLK) disable iff (!RST_N)
    (state_r == WAIT && perr_r && ctrl_r[CTRL_DRV_EN]) |=> ADDRESS_ERROR_OE;
  endproperty
  a_err_on_fault: assert property (p_err_on_fault) else $error("parity fault not signalled");

  property p_upper_out_of_range;
    @(posedge MCLK) disable iff (!RST_N)
    (state_r == WAIT && !in_range && !perr_lo_r && !perr_rp_r) |=> !ADDRESS_ERROR_OE;
  endproperty
  a_upper_out_of_range: assert property (p_upper_out_of_range) else $error("upper parity blamed out of range");

  property p_cancel_resets_arb;
    @(posedge MCLK) disable iff (!RST_N)
    cancel_now |=> ARB_PRIORITY_RESET ##1 !ARB_PRIORITY_RESET;
  endproperty
  a_cancel_resets_arb: assert property (p_cancel_resets_arb) else $error("arbitration reset missing");

  property p_second_cancel_hard;
    @(posedge MCLK) disable iff (!RST_N)
    (cancel_now && same_addr) |=> sts_r[ST_HARD] && !tried_r;
  endproperty
  a_second_cancel_hard: assert property (p_second_cancel_hard) else $error("second cancel not hard");

  property p_write_ready_cause;
    @(posedge MCLK) disable iff (!RST_N)
    !WRITE_DATA_READY_N |-> $past(is_write) && $past(accept) && state_r == SNOOP;
  endproperty
  a_write_ready_cause: assert property (p_write_ready_cause) else $error("write handshake without accepted write");

  property p_tag_clash_flag;
    @(posedge MCLK) disable iff (!RST_N)
    (state_r == WAIT && tag_clash) |=> sts_r[ST_TAG];
  endproperty
  a_tag_clash_flag: assert property (p_tag_clash_flag) else $error("tag reuse not flagged");
endmodule : brq_observer
`default_nettype wire

// [verilog/brq_pkg.sv]
/*
  Shared constants and carrier types for the bus request observer.
  Assumes a 32-bit APB register port and active-low request pins.
*/
`default_nettype none
package brq_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FIELDA  = 8'h08;
  localparam logic [7:0] OFS_ADDRLO  = 8'h0C;
  localparam logic [7:0] OFS_ADDRHI  = 8'h10;
  localparam logic [7:0] OFS_FIELDB  = 8'h14;
  localparam logic [7:0] OFS_COUNT   = 8'h18;
  localparam logic [7:0] OFS_DECODE  = 8'h1C;
  // Control bit positions and reset value.
  localparam int CTRL_DRV_EN  = 0;
  localparam int CTRL_OBS_EN  = 1;
  localparam int CTRL_WIDE    = 2;
  localparam int CTRL_OWN_MEM = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Sticky status bit positions.
  localparam int ST_PARITY = 0;
  localparam int ST_CANCEL = 1;
  localparam int ST_HARD   = 2;
  localparam int ST_DSZ    = 3;
  localparam int ST_RSVD   = 4;
  localparam int ST_DEN    = 5;
  localparam int ST_TAG    = 6;
  localparam int ST_LEN16  = 7;
  localparam int ST_BITS   = 8;
  // Field encodings (logical, asserted = 1).
  localparam logic [1:0] ASZ_4G   = 2'h0;
  localparam logic [1:0] ASZ_64G  = 2'h1;
  localparam logic [1:0] LEN_8    = 2'h0;
  localparam logic [1:0] LEN_16   = 2'h1;
  localparam logic [1:0] LEN_32   = 2'h2;
  localparam logic [1:0] DSZ_OK   = 2'h0;
  localparam logic [7:0] ATTR_UC  = 8'h00;
  localparam logic [7:0] ATTR_WC  = 8'h04;
  localparam logic [7:0] ATTR_WB  = 8'h07;
  localparam logic [7:0] SPC_FIRST = 8'h01;
  localparam logic [7:0] SPC_LAST  = 8'h07;
  localparam logic [4:0] CMD_SPECIAL = 5'h08;
  localparam logic [1:0] CMDB_SPECIAL = 2'h1;
  localparam logic [4:0] CMD_DEF_REPLY = 5'h00;
  // Extended function bit positions.
  localparam int EXF_MGMT  = 4;
  localparam int EXF_SPLIT = 3;
  localparam int EXF_DEN   = 1;
  // Phase offset from the strobe clock and deferrable tag count.
  localparam int ERR_DELAY = 3;
  localparam int TAGS      = 256;

  typedef struct packed {
    logic        strobe_n;
    logic [4:0]  cmd_n;
    logic [35:3] addr_n;
    logic [1:0]  ap_n;
    logic        rp_n;
    logic        lock_n;
    logic        defer_n;
    logic        address_error_n;
  } brq_pins_t;

  typedef struct packed {
    logic [4:0]  cmd_a;
    logic [4:0]  cmd_b;
    logic [35:3] addr;
    logic [7:0]  attr;
    logic [7:0]  tag;
    logic [7:0]  be;
    logic [4:0]  exf;
    logic        locked;
  } brq_req_t;
endpackage : brq_pkg
`default_nettype wire

// [bench/brq_requester.sv]
/*
  Requesting agent model: drives both request clocks with parity, the error
  phase and the snoop defer line onto pulled-up bus pins.
  Assumes one go pulse per request, at least eight clocks apart.
*/
`timescale 1ns/1ps
`default_nettype none
module brq_requester
  import brq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request orders
  input  wire logic       go,
  input  wire brq_req_t   req,
  input  wire logic [2:0] bad,
  input  wire logic       err_en,
  input  wire logic       defer_en,
  // Bus pins
  output var  brq_pins_t  pins
);
  logic [2:0] ph_r;

  // Parity pins keep the count of low lines even unless a flip is ordered.
  function automatic brq_pins_t frame(input logic s, input logic [4:0] c, input logic [35:3] a,
                                      input logic [2:0] b, input logic lk, input logic ae, input logic df);
    brq_pins_t f;
    f.strobe_n = s;
    f.cmd_n    = c;
    f.addr_n   = a;
    f.ap_n[1]  = ~^(~a[35:24]) ^ b[1];
    f.ap_n[0]  = ~^(~a[23:3]) ^ b[0];
    f.rp_n     = ~^(~{c, s}) ^ b[2];
    f.lock_n   = lk;
    f.defer_n  = df;
    f.address_error_n   = ae;
    return f;
  endfunction : frame

  // Released lines go to the pull-up level, so idle is all ones.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 3'h0;
      pins <= frame(1'b1, '1, '1, 3'h0, 1'b1, 1'b1, 1'b1);
    end else begin
      ph_r <= (go || ph_r != 3'h0) ? ph_r + 3'h1 : 3'h0;
      case (ph_r)
        3'h0: if (go) pins <= frame(1'b0, ~req.cmd_a, ~req.addr, bad, ~req.locked, 1'b1, 1'b1);
        3'h1: pins <= frame(1'b1, ~req.cmd_b, ~{4'h0, req.attr, req.tag, req.be, req.exf}, bad, pins.lock_n,
                            1'b1, 1'b1);
        3'h2: pins <= frame(1'b1, '1, '1, 3'h0, pins.lock_n, 1'b1, 1'b1);
        3'h3: pins <= frame(1'b1, '1, '1, 3'h0, pins.lock_n, ~err_en, 1'b1);
        3'h4: pins <= frame(1'b1, '1, '1, 3'h0, pins.lock_n, 1'b1, ~defer_en);
        default: pins <= frame(1'b1, '1, '1, 3'h0, 1'b1, 1'b1, 1'b1);
      endcase
    end
  end
endmodule : brq_requester
`default_nettype wire

// [bench/brq_observer_test.sv]
/*
  Self-checking bench for the bus request observer: APB master, requesting
  agent model, random and corner requests, pulse counting on the outputs.
  Assumes zero-wait APB and outputs settled within twelve clocks of a strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module brq_observer_test
  import brq_pkg::*;
;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, ae_o, ae_oe, wdr_n, arb;
  logic        go, err_en, defer_en, slv, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ctl;
  logic [2:0]  bad, b;
  brq_req_t    req, r;
  brq_pins_t   pins, bus;
  int          err_total, checked, cyc, n_oe, n_arb, n_wdr, n_req, n_can, tg;
  logic [7:0]  kinds [5] = '{ATTR_UC, ATTR_WC, 8'h05, 8'h06, ATTR_WB};

  // The error line is open drain: any party enabling its driver pulls it low.
  always_comb begin
    bus        = pins;
    bus.address_error_n = pins.address_error_n & ~(ae_oe & ~ae_o);
  end

  brq_observer dut_u (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS_IN(bus),
    .ADDRESS_ERROR_O(ae_o), .ADDRESS_ERROR_OE(ae_oe), .WRITE_DATA_READY_N(wdr_n), .ARB_PRIORITY_RESET(arb));
  brq_requester req_u (.clk(mclk), .rst_n(rst_n), .go(go), .req(req), .bad(bad), .err_en(err_en),
    .defer_en(defer_en), .pins(pins));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    n_oe  += int'(ae_oe === 1'b1);
    n_arb += int'(arb === 1'b1);
    n_wdr += int'(wdr_n === 1'b0);
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic brq_req_t base();
    brq_req_t q;
    q.cmd_a  = {ASZ_4G, 3'b110};
    q.cmd_b  = {3'h0, LEN_8};
    q.addr   = {4'h0, 29'($urandom())};
    q.attr   = ATTR_WB;
    q.tag    = 8'(tg);
    q.be     = 8'hFF;
    q.exf    = 5'h0;
    q.locked = 1'b0;
    tg++;
    return q;
  endfunction : base

  task automatic one(input brq_req_t q, input logic [3:0] c, input logic [2:0] fl, input logic er,
                     input logic df, input logic [7:0] extra);
    logic        mem, spc, inr, acc, flt, can;
    logic [7:0]  st;
    logic [31:0] msk;
    int          o, a, w;
    mem = q.cmd_a[2] | q.cmd_a[1];
    spc = q.cmd_a == CMD_SPECIAL && q.cmd_b[1:0] == CMDB_SPECIAL;
    inr = q.cmd_a[4:3] == ASZ_4G || (c[CTRL_WIDE] && q.cmd_a[4:3] == ASZ_64G);
    acc = mem && inr && (!q.exf[EXF_MGMT] || c[CTRL_OWN_MEM]);
    flt = c[CTRL_DRV_EN] && (fl[0] || fl[2] || (fl[1] && inr));
    can = c[CTRL_OBS_EN] && (er || flt);
    st = extra;
    st[ST_PARITY] = flt;
    st[ST_CANCEL] = can;
    st[ST_DSZ] = q.cmd_b[4:3] != 2'h0;
    st[ST_RSVD] = (mem && (q.cmd_a[4] || q.cmd_b[1:0] == 2'h3 || !(q.attr inside {kinds})))
                  || (spc && !(q.be inside {[SPC_FIRST:SPC_LAST]}));
    st[ST_DEN] = (q.exf[EXF_DEN] && (q.locked || q.cmd_a == CMD_DEF_REPLY || q.cmd_a[2:0] == 3'h5)) ||
                 (q.exf[EXF_SPLIT] && !q.locked);
    st[ST_LEN16] = mem && q.cmd_b[1:0] == LEN_16;
    msk = mem ? 32'h00000F1F : 32'h00000F17;
    apb(1'b1, OFS_CTRL, {28'h0, c});
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    o = n_oe;
    a = n_arb;
    w = n_wdr;
    @(posedge mclk);
    req      <= q;
    bad      <= fl;
    err_en   <= er;
    defer_en <= df;
    go       <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (12) @(posedge mclk);
    n_req++;
    n_can += int'(can);
    chk("error pulses", 32'(flt), n_oe - o);
    chk("arbitration pulses", 32'(can), n_arb - a);
    chk("write ready pulses", 32'(acc && q.cmd_a[0] && !can), n_wdr - w);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", {24'h0, st}, rd);
    apb(1'b0, OFS_FIELDA, 32'h0);
    chk("commands", {19'h0, q.cmd_b, 3'h0, q.cmd_a}, rd);
    apb(1'b0, OFS_ADDRLO, 32'h0);
    chk("address low", {q.addr[31:3], 3'h0}, rd);
    apb(1'b0, OFS_ADDRHI, 32'h0);
    chk("address high", {28'h0, q.addr[35:32]}, rd);
    apb(1'b0, OFS_FIELDB, 32'h0);
    chk("second clock", {3'h0, q.exf, q.be, q.tag, q.attr}, rd);
    apb(1'b0, OFS_DECODE, 32'h0);
    chk("decode", {20'h0, q.be[3:0], 3'h0, spc, acc, q.cmd_a[1], q.cmd_a[0], mem} & msk, rd & msk);
  endtask : one

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, go, bad, err_en, defer_en} = '0;
    req = '0;
    void'($urandom(32'h5126AE78));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("control reset", {28'h0, CTRL_RESET}, rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("unmapped write error", 32'h1, 32'(slv));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read data", 32'h0, rd);
    for (int i = 0; i < 24; i++) begin
      r = base();
      r.addr[35:32] = 4'($urandom_range(0, 1) * $urandom_range(1, 15));
      r.cmd_a = {(r.addr[35:32] != 4'h0) ? ASZ_64G : ASZ_4G, 1'b1, 2'($urandom())};
      r.cmd_b[1:0] = $urandom_range(0, 1) ? LEN_32 : LEN_8;
      r.attr = kinds[$urandom_range(0, 4)];
      r.be = (r.cmd_b[1:0] == LEN_32) ? 8'hFF : 8'($urandom());
      r.exf[EXF_DEN] = r.cmd_a[1:0] != 2'b01 && $urandom_range(0, 1) == 1;
      b = ($urandom_range(0, 3) == 0) ? 3'($urandom()) : 3'h0;
      one(r, 4'($urandom()), b, $urandom_range(0, 3) == 0, 1'b0, 8'h0);
    end
    for (int k = 0; k < 26; k++) begin
      r = base();
      {ctl, b, e} = {4'h3, 3'h0, 1'b0};
      case (k)
        0: r.cmd_b[1:0] = 2'h3;
        1: r.cmd_b[4:3] = 2'h1;
        2: r.cmd_b[1:0] = LEN_16;
        3: r.attr = 8'h01;
        4: r.cmd_a[4:3] = 2'h2;
        5: {r.locked, r.exf[EXF_DEN]} = 2'h3;
        6: r.exf[EXF_SPLIT] = 1'b1;
        7: {r.locked, r.exf[EXF_SPLIT]} = 2'h3;
        8: {r.cmd_a, r.exf[EXF_DEN]} = {CMD_DEF_REPLY, 1'b1};
        9: {r.cmd_a[4:3], r.addr[35:32], b} = {ASZ_64G, 4'h9, 3'h2};
        10: {r.cmd_a[4:3], r.addr[35:32], b, ctl} = {ASZ_64G, 4'h9, 3'h2, 4'h7};
        11: {b, ctl} = {3'h1, 4'h2};
        12: b = 3'h4;
        13: {r.cmd_a[1:0], r.exf[EXF_MGMT]} = 3'h7;
        14: {r.cmd_a[1:0], r.exf[EXF_MGMT], ctl} = {3'h7, 4'hB};
        15: {e, ctl} = {1'b1, 4'h1};
        16: {r.cmd_a[2:0], r.exf[EXF_DEN]} = {3'h5, 1'b1};
        default: {r.cmd_a, r.cmd_b, r.be} = {CMD_SPECIAL, 3'h0, CMDB_SPECIAL, 8'(k - 17)};
      endcase
      one(r, ctl, b, e, 1'b0, 8'h0);
    end
    // A write cancelled twice at one address exhausts its single retry.
    r = base();
    r.cmd_a[0] = 1'b1;
    one(r, 4'h3, 3'h0, 1'b1, 1'b0, 8'h0);
    one(r, 4'h3, 3'h0, 1'b1, 1'b0, 8'h1 << ST_HARD);
    r = base();
    r.exf[EXF_DEN] = 1'b1;
    one(r, 4'h3, 3'h0, 1'b0, 1'b1, 8'h0);
    one(r, 4'h3, 3'h0, 1'b0, 1'b0, 8'h1 << ST_TAG);
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("counts", {16'(n_req), 16'(n_can)}, rd);
    give_verdict();
  end
endmodule : brq_observer_test
`default_nettype wire
